// ==== logic/urb_pkg.sv ====
package urb_pkg;
  // ----------------------------------------------------------------
  // widths and counts
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam logic [3:0]  SAMPLE_MID = 4'h7;   // eighth receive clock of a bit
  localparam logic [3:0]  SAMPLE_END = 4'hf;   // sixteenth receive clock of a bit
  localparam logic [3:0]  WORD_LEN_BASE = 4'h5;
  localparam logic [2:0]  BIT_IDX_ZERO = 3'h0;
  localparam logic [3:0]  CNT_ZERO = 4'h0;
  localparam logic [3:0]  CNT_ONE = 4'h1;
  localparam logic [2:0]  IDX_ONE = 3'h1;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [1:0]        WLS_RST = 2'h0;
  localparam logic [3:0]        CNT_RST = 4'h0;
  // ----------------------------------------------------------------
  // receiver states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    URB_IDLE,
    URB_START,
    URB_DATA,
    URB_PARITY,
    URB_STOP
  } urb_state_type;
endpackage

// ==== logic/urb_receive_buffer.sv ====
`timescale 1ns/1ps
module urb_receive_buffer
(
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_resetn,
  input  wire logic                      i_receive_bit_clock,
  input  wire logic                      i_line_receive_input,
  input  wire logic                      i_master_clear,
  input  wire logic                      i_config_latch_strobe,
  input  wire logic                      i_parity_inhibit,
  input  wire logic                      i_parity_sense_select,
  input  wire logic                      i_word_size_sel_low,
  input  wire logic                      i_word_size_sel_high,
  input  wire logic                      i_stop_count_select,
  input  wire logic                      i_ready_clear_input_n,
  input  wire logic                      i_parallel_output_disable,
  input  wire logic                      i_flag_outputs_disable,
  output logic        [urb_pkg::DATA_W-1:0] o_parallel_receive_bits,
  output logic                           o_parallel_receive_bits_oe,
  output logic                           o_parity_error_flag,
  output logic                           o_framing_error_flag,
  output logic                           o_overrun_error_flag,
  output logic                           o_data_ready_flag,
  output logic                           o_status_flags_oe,
  output logic                           o_serial_tx_line
);
  import urb_pkg::*;

  // ----------------------------------------------------------------
  // configuration latch
  // ----------------------------------------------------------------
  // stop count only matters to the transmitter; the receiver checks
  // the first stop bit and treats a second one as idle line
  logic       cfg_pi;
  logic       cfg_ps;
  logic [1:0] cfg_wls;
  logic       cfg_sbs;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_pi  <= 1'b0;
      cfg_ps  <= 1'b0;
      cfg_wls <= WLS_RST;
      cfg_sbs <= 1'b0;
    end else if (i_config_latch_strobe) begin
      cfg_pi  <= i_parity_inhibit;
      cfg_ps  <= i_parity_sense_select;
      cfg_wls <= {i_word_size_sel_high, i_word_size_sel_low};
      cfg_sbs <= i_stop_count_select;
    end
  end

  // ----------------------------------------------------------------
  // receive clock edge and decode
  // ----------------------------------------------------------------
  logic          rc_q;
  urb_state_type state;
  logic [3:0]    cnt;
  logic [2:0]    bit_idx;
  logic [DATA_W-1:0] shreg;
  logic          par_bit;
  logic [DATA_W-1:0] hold;
  logic          dr;
  logic          line_q;

  wire       rc_rise   = i_receive_bit_clock & ~rc_q;
  wire       start_edge = line_q & ~i_line_receive_input;
  wire [3:0] word_len  = WORD_LEN_BASE + {2'h0, cfg_wls};
  wire [2:0] last_idx  = 3'(word_len - CNT_ONE);
  wire       mid_hit   = rc_rise && (cnt == SAMPLE_MID);
  wire       end_hit   = rc_rise && (cnt == SAMPLE_END);
  wire       xfer      = end_hit && (state == URB_STOP);
  wire       data_par  = ^shreg;
  wire       par_err   = ~cfg_pi & (data_par ^ par_bit ^ ~cfg_ps);
  wire       stop_bad  = ~i_line_receive_input;

  function automatic logic [DATA_W-1:0] len_mask(input logic [1:0] wls);
    len_mask = 8'hff >> (2'h3 - wls);
  endfunction

  wire [DATA_W-1:0] word_masked = shreg & len_mask(cfg_wls);

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rc_q <= 1'b1;
    end else begin
      rc_q <= i_receive_bit_clock;
    end
  end

  // ----------------------------------------------------------------
  // receiver sequencer
  // ----------------------------------------------------------------
  // only a high-to-low step of the line is a start edge, so a line left
  // low after a bad stop bit cannot launch a phantom word; a start bit
  // that is high again at its centre was a glitch and is dropped
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      line_q  <= 1'b1;
      state   <= URB_IDLE;
      cnt     <= CNT_RST;
      bit_idx <= BIT_IDX_ZERO;
      shreg   <= DATA_RST;
      par_bit <= 1'b0;
    end else if (rc_rise) begin
      line_q <= i_line_receive_input;
      cnt    <= 4'(cnt + CNT_ONE);
      unique case (state)
        URB_IDLE: begin
          cnt <= CNT_ZERO;
          if (start_edge) begin
            state <= URB_START;
            cnt   <= CNT_ONE;
          end
        end
        URB_START: begin
          if (cnt == SAMPLE_MID) begin
            cnt     <= CNT_ZERO;
            bit_idx <= BIT_IDX_ZERO;
            shreg   <= DATA_RST;
            state   <= i_line_receive_input ? URB_IDLE : URB_DATA;
          end
        end
        URB_DATA: begin
          if (cnt == SAMPLE_END) begin
            shreg[bit_idx] <= i_line_receive_input;
            bit_idx        <= 3'(bit_idx + IDX_ONE);
            if (bit_idx == last_idx) begin
              state <= cfg_pi ? URB_STOP : URB_PARITY;
            end
          end
        end
        URB_PARITY: begin
          if (cnt == SAMPLE_END) begin
            par_bit <= i_line_receive_input;
            state   <= URB_STOP;
          end
        end
        URB_STOP: begin
          if (cnt == SAMPLE_END) begin
            state <= URB_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // holding buffer and status flags
  // ----------------------------------------------------------------
  // the held word is static; master clear leaves it alone
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hold <= DATA_RST;
    end else if (xfer) begin
      hold <= word_masked;
    end
  end

  // ready clear is a level: while held low it beats a new word
  wire next_dr = ~i_ready_clear_input_n ? 1'b0 : (xfer ? 1'b1 : dr);

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dr                   <= 1'b0;
      o_parity_error_flag  <= 1'b0;
      o_framing_error_flag <= 1'b0;
      o_overrun_error_flag <= 1'b0;
      o_serial_tx_line     <= 1'b1;
    end else if (i_master_clear) begin
      dr                   <= 1'b0;
      o_parity_error_flag  <= 1'b0;
      o_framing_error_flag <= 1'b0;
      o_overrun_error_flag <= 1'b0;
      o_serial_tx_line     <= 1'b1;
    end else begin
      dr <= next_dr;
      if (xfer) begin
        o_parity_error_flag  <= par_err;
        o_framing_error_flag <= stop_bad;
        o_overrun_error_flag <= dr;
      end else if (cfg_pi) begin
        o_parity_error_flag  <= 1'b0;
      end
    end
  end

  assign o_data_ready_flag = dr;

  // ----------------------------------------------------------------
  // output drivers
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_parallel_receive_bits    <= DATA_RST;
      o_parallel_receive_bits_oe <= 1'b0;
      o_status_flags_oe          <= 1'b0;
    end else begin
      o_parallel_receive_bits    <= xfer ? word_masked : hold;
      o_parallel_receive_bits_oe <= ~i_parallel_output_disable;
      o_status_flags_oe          <= ~i_flag_outputs_disable;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  out_disable_a: assert property (i_parallel_output_disable |=> !o_parallel_receive_bits_oe)
    else $error("parallel outputs not floated");
  flag_disable_a: assert property (i_flag_outputs_disable |=> !o_status_flags_oe)
    else $error("flag outputs not floated");
  ready_clear_a: assert property (!i_ready_clear_input_n |=> !o_data_ready_flag)
    else $error("ready flag not cleared");
  ready_set_a: assert property (xfer && i_ready_clear_input_n && !i_master_clear
                                |=> o_data_ready_flag && o_parallel_receive_bits == hold)
    else $error("ready flag or data missing after transfer");
  overrun_set_a: assert property (xfer && dr && !i_master_clear |=> o_overrun_error_flag)
    else $error("overrun not flagged");
  frame_err_a: assert property (xfer && !i_line_receive_input && !i_master_clear
                                |=> o_framing_error_flag)
    else $error("framing error not flagged");
  short_word_a: assert property (xfer && cfg_wls == 2'h0 |=> hold[7:5] == 3'h0)
    else $error("unused upper bits not low");
  par_inhibit_a: assert property (cfg_pi && $past(cfg_pi) |-> !o_parity_error_flag)
    else $error("parity error while inhibited");
  master_clear_a: assert property (i_master_clear |=> !dr && !o_overrun_error_flag && o_serial_tx_line
                                   && $stable(hold))
    else $error("master clear effect wrong");
  false_start_a: assert property (state == URB_START && mid_hit && i_line_receive_input
                                  |=> state == URB_IDLE)
    else $error("false start not abandoned");
  bit_period_a: assert property (state == URB_DATA && end_hit |=> cnt == CNT_ZERO)
    else $error("bit period not sixteen clocks");
  hold_static_a: assert property (!xfer |=> $stable(hold))
    else $error("holding buffer changed without transfer");

endmodule // urb_receive_buffer

// ==== bench/urb_line_tx.sv ====
`timescale 1ns/1ps
module urb_line_tx (
  input  wire logic i_ref_clk,
  input  wire logic i_bit_clk,
  output logic      o_line
);
  // ----------------------------------------------------------------
  // remote serial sender
  // ----------------------------------------------------------------
  initial begin
    o_line = 1'h1;
  end
  task automatic hold_bit(input logic v);
    @(negedge i_ref_clk);
    o_line = v;
    repeat (16) @(posedge i_bit_clk);
  endtask
  // trailing idle bit keeps the line high before any next start edge
  task automatic send(input logic [7:0] d, input int n, input logic pen, input logic par, input logic stop);
    hold_bit(1'h0);
    for (int i = 0; i < n; i++) hold_bit(d[i]);
    if (pen) hold_bit(par);
    hold_bit(stop);
    hold_bit(1'h1);
  endtask
  // low pulse far shorter than half a bit
  task automatic glitch();
    hold_bit(1'h1);
    @(negedge i_ref_clk);
    o_line = 1'h0;
    repeat (4) @(posedge i_bit_clk);
    hold_bit(1'h1);
  endtask
endmodule // urb_line_tx

// ==== bench/urb_receive_buffer_tb_top.sv ====
`timescale 1ns/1ps
module urb_receive_buffer_tb_top;
  import urb_pkg::*;
  logic       clk, rstn, bclk, line, mclr, pi, ps, wl, wh, rdy_n, pod, flag_outputs_disable, config_latch_strobe;
  logic [7:0] dat;
  logic       dat_oe, pe, fe, ovr, dr, fl_oe, tx;
  int         err_count, n_tests;
  urb_receive_buffer i_urb_receive_buffer (.i_ref_clk(clk), .i_resetn(rstn), .i_receive_bit_clock(bclk),
    .i_line_receive_input(line), .i_master_clear(mclr), .i_config_latch_strobe(config_latch_strobe),
    .i_parity_inhibit(pi), .i_parity_sense_select(ps), .i_word_size_sel_low(wl), .i_word_size_sel_high(wh),
    .i_stop_count_select(1'h0), .i_ready_clear_input_n(rdy_n), .i_parallel_output_disable(pod),
    .i_flag_outputs_disable(flag_outputs_disable), .o_parallel_receive_bits(dat), .o_parallel_receive_bits_oe(dat_oe),
    .o_parity_error_flag(pe), .o_framing_error_flag(fe), .o_overrun_error_flag(ovr),
    .o_data_ready_flag(dr), .o_status_flags_oe(fl_oe), .o_serial_tx_line(tx));
  urb_line_tx i_urb_line_tx (.i_ref_clk(clk), .i_bit_clk(bclk), .o_line(line));
  // ----------------------------------------------------------------
  // clocks: bit clock is a quarter of the reference rate
  // ----------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    bclk = 1'h0;
    forever begin
      repeat (2) @(negedge clk);
      bclk = ~bclk;
    end
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic finish_test();
    if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // parity worked out from the current sense; bad_par flips it
  task automatic frame(input logic [7:0] d, input int n, input logic bad_par, input logic stop);
    logic [7:0] dm;
    dm = d & (8'hff >> (8 - n));
    i_urb_line_tx.send(d, n, !pi, (^dm) ^ !ps ^ bad_par, stop);
    @(negedge clk);
  endtask
  task automatic clear_ready();
    @(negedge clk);
    rdy_n = 1'h0;
    @(negedge clk);
    rdy_n = 1'h1;
    @(negedge clk);
  endtask
  initial begin
    #200000;
    err_count++;
    finish_test();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    err_count = 0;
    n_tests = 0;
    {rstn, mclr, pi, ps, wl, wh, rdy_n, pod, flag_outputs_disable} = 9'h004;
    config_latch_strobe = 1'h1;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rstn = 1'h1;
    // config follows the select inputs while the strobe stays high
    for (int n = 5; n <= 8; n++) begin
      {wh, wl} = 2'(n - 5);
      ps = n[0];
      frame(8'hb6, n, 1'h0, 1'h1);
      chk(dat, 8'hb6 & (8'hff >> (8 - n)));
      chk({dr, pe, fe, ovr}, 8'h08);
      clear_ready();
      chk(dr, 8'h00);
    end
    frame(8'h3c, 8, 1'h0, 1'h1);
    frame(8'hc3, 8, 1'h0, 1'h1);
    chk(dat, 8'hc3);
    chk({dr, ovr}, 8'h03);
    clear_ready();
    frame(8'h5a, 8, 1'h1, 1'h1);
    chk({dr, pe, fe, ovr}, 8'h0c);
    clear_ready();
    frame(8'h81, 8, 1'h0, 1'h0);
    chk({dr, pe, fe, ovr}, 8'h0a);
    mclr = 1'h1;
    @(negedge clk);
    mclr = 1'h0;
    repeat (2) @(negedge clk);
    chk({dr, pe, fe, ovr, tx}, 8'h01);
    chk(dat, 8'h81);
    pi = 1'h1;
    frame(8'h7e, 8, 1'h1, 1'h1);
    chk({dr, pe, fe, ovr}, 8'h08);
    chk(dat, 8'h7e);
    clear_ready();
    i_urb_line_tx.glitch();
    repeat (80) @(negedge clk);
    chk({dr, fe}, 8'h00);
    chk(dat, 8'h7e);
    // strobe low: a word length change must not reach the receiver
    config_latch_strobe = 1'h0;
    {wh, wl} = 2'h0;
    frame(8'ha5, 8, 1'h0, 1'h1);
    chk(dat, 8'ha5);
    chk({dr, pe, fe, ovr}, 8'h08);
    config_latch_strobe = 1'h1;
    {wh, wl} = 2'h3;
    clear_ready();
    pod = 1'h1;
    flag_outputs_disable = 1'h1;
    repeat (2) @(negedge clk);
    chk({dat_oe, fl_oe}, 8'h00);
    pod = 1'h0;
    repeat (2) @(negedge clk);
    chk({dat_oe, fl_oe}, 8'h02);
    flag_outputs_disable = 1'h0;
    repeat (2) @(negedge clk);
    chk({dat_oe, fl_oe}, 8'h03);
    finish_test();
  end
endmodule // urb_receive_buffer_tb_top
